// [shared/vmearb_pkg.sv]
// Constants and types shared by the backplane system controller and the board end.
// Assumes a single 100 MHz core clock on both ends.
`default_nettype none
package vmearb_pkg;
  localparam int NUM_SLOTS  = 8;
  localparam int BR_LEVELS  = 4;
  localparam int IRQ_LEVELS = 7;
  localparam int VEC_W      = 8;
  localparam int LVL_W      = 3;
  localparam int CFG_W      = 3;

  localparam int CFG_PRI_BIT = 0;
  localparam int CFG_RR_BIT  = 1;
  localparam int CFG_ROR_BIT = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h1;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int ACK_TIMEOUT_NS = 1000;
  localparam logic [7:0] ACK_TIMEOUT_CYC = 8'(ACK_TIMEOUT_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_BUSY, ARB_OWN} vmearb_arb_type;
  typedef enum logic [2:0] {HND_IDLE, HND_REQ, HND_ADDR, HND_STROBE, HND_DONE} vmearb_hnd_type;
endpackage : vmearb_pkg
`default_nettype wire

// [shared/vmearb_if.sv]
// Backplane wiring between the system controller and the boards in the slots.
// Open-drain lines are pulled low where any enable is low and read high otherwise.
`timescale 1ns/1ps
`default_nettype none
interface vmearb_if;
  import vmearb_pkg::*;
  logic [BR_LEVELS-1:0]  br_oe_n;      // Bus request drives from boards.
  logic [BR_LEVELS-1:0]  bg_n;         // Bus grant into the first slot.
  logic                  bbsy_bd_oe_n; // Bus busy drive from boards.
  logic                  bbsy_sc_oe_n; // Bus busy drive from the controller.
  logic                  bclr_oe_n;    // Bus clear drive, never enabled.
  logic [IRQ_LEVELS:1]   irq_oe_n;     // Interrupt request drives from boards.
  logic                  iack_n;       // Interrupt acknowledge into the first slot.
  logic                  as_n;         // Address strobe.
  logic                  ds_n;         // Data strobe.
  logic [LVL_W:1]        addr_drv;     // A03..A01 driven by the controller.
  logic                  addr_oe_n;    // Address drive enable.
  logic [VEC_W-1:0]      data_drv;     // Status/ID byte from the answering board.
  logic                  data_oe_n;    // Data drive enable.
  logic                  dtack_oe_n;   // Acknowledge drive from boards.
  wire [BR_LEVELS-1:0]   br_n     = br_oe_n;
  wire                   bbsy_n   = bbsy_bd_oe_n & bbsy_sc_oe_n;
  wire                   bclr_n   = bclr_oe_n;
  wire [IRQ_LEVELS:1]    irq_n    = irq_oe_n;
  wire                   dtack_n  = dtack_oe_n;
  wire [LVL_W:1]         addr     = addr_oe_n ? 3'h7 : addr_drv;
  wire [VEC_W-1:0]       data     = data_oe_n ? 8'hFF : data_drv;
  modport sysctl (output bg_n, bbsy_sc_oe_n, bclr_oe_n, iack_n, as_n, ds_n, addr_drv,
                  addr_oe_n, input br_n, bbsy_n, irq_n, dtack_n, data);
  modport boards (output br_oe_n, bbsy_bd_oe_n, irq_oe_n, data_drv, data_oe_n, dtack_oe_n,
                  input bg_n, bbsy_n, iack_n, as_n, ds_n, addr, bclr_n);
endinterface : vmearb_if
`default_nettype wire

// [hw/vmearb_boards.sv]
// Board end: requesters in NUM_SLOTS slots, slot 0 first on both daisy chains.
// Assumes the controller grants only while the bus is free and acknowledges one level.
`timescale 1ns/1ps
`default_nettype none
module vmearb_boards
  import vmearb_pkg::*;
(
  input  wire logic                            i_core_clk,   // Core clock.
  input  wire logic                            i_sys_rst,    // Synchronous reset, high.
  vmearb_if.boards                             bus,          // Backplane.
  input  wire logic [NUM_SLOTS-1:0]            i_bus_req,    // Slot wants the bus.
  input  wire logic [NUM_SLOTS-1:0][1:0]       i_br_level,   // Request level per slot.
  input  wire logic [NUM_SLOTS-1:0]            i_irq_req,    // Pulse: raise interrupt.
  input  wire logic [NUM_SLOTS-1:0][LVL_W-1:0] i_irq_level,  // Interrupt level, 0 none.
  input  wire logic [NUM_SLOTS-1:0]            i_vec_we,     // Write vector register.
  input  wire logic [NUM_SLOTS-1:0][VEC_W-1:0] i_vec_wdata,  // Vector to store.
  output logic      [NUM_SLOTS-1:0]            o_bus_own_q,  // Slot holds the bus.
  output logic      [NUM_SLOTS-1:0]            o_irq_acked_q // Pulse: slot answered.
);
  logic                           as_prev_q;
  logic [NUM_SLOTS:0][BR_LEVELS-1:0] bg_chain;
  logic [NUM_SLOTS:0]             iack_chain;
  logic [NUM_SLOTS:0][BR_LEVELS-1:0] br_acc;
  logic [NUM_SLOTS:0][IRQ_LEVELS:1]  irq_acc;
  logic [NUM_SLOTS:0][VEC_W-1:0]  data_acc;
  logic [NUM_SLOTS:0]             own_acc;
  logic [NUM_SLOTS:0]             resp_acc;
  logic [NUM_SLOTS-1:0]           own_q;
  logic [NUM_SLOTS-1:0]           irq_q;
  logic [NUM_SLOTS-1:0]           resp_q;
  logic [NUM_SLOTS-1:0][VEC_W-1:0] vec_q;

  wire as_fall = as_prev_q & ~bus.as_n;
  assign bg_chain[0]   = ~bus.bg_n;
  assign iack_chain[0] = ~bus.iack_n;
  assign br_acc[0]     = '0;
  assign irq_acc[0]    = '0;
  assign data_acc[0]   = '0;
  assign own_acc[0]    = 1'b0;
  assign resp_acc[0]   = 1'b0;

  for (genvar s = 0; s < NUM_SLOTS; s++)
  begin : g_slot
    wire want  = i_bus_req[s] & ~own_q[s];
    wire bg_in = bg_chain[s][i_br_level[s]];
    // The grant still stands for a cycle after the winner takes the bus, so a board that
    // sees the bus busy must leave it alone or a second board downstream would take it too.
    wire take  = want & bg_in & bus.bbsy_n;
    wire own_d = take | (own_q[s] & i_bus_req[s]);
    wire match = irq_q[s] & (i_irq_level[s] == bus.addr) & (i_irq_level[s] != 3'h0);
    wire hit   = as_fall & iack_chain[s] & match;
    wire resp_d = hit | (resp_q[s] & ~bus.as_n);
    wire irq_d  = (i_irq_req[s] & (i_irq_level[s] != 3'h0)) | (irq_q[s] & ~hit);
    logic [BR_LEVELS-1:0] br_one;
    logic [IRQ_LEVELS:1]  irq_one;
    always_comb
    begin
      br_one = '0;
      br_one[i_br_level[s]] = want;
      irq_one = '0;
      if (i_irq_level[s] != 3'h0)
      begin
        irq_one[i_irq_level[s]] = irq_q[s];
      end
    end
    assign bg_chain[s+1]   = bg_chain[s] & ~br_one;
    assign iack_chain[s+1] = iack_chain[s] & ~match;
    assign br_acc[s+1]     = br_acc[s] | br_one;
    assign irq_acc[s+1]    = irq_acc[s] | irq_one;
    assign data_acc[s+1]   = data_acc[s] | (resp_d ? vec_q[s] : 8'h00);
    assign own_acc[s+1]    = own_acc[s] | own_d;
    assign resp_acc[s+1]   = resp_acc[s] | resp_d;
    always_ff @(posedge i_core_clk)
    begin
      if (i_sys_rst)
      begin
        own_q[s]         <= 1'b0;
        irq_q[s]         <= 1'b0;
        resp_q[s]        <= 1'b0;
        vec_q[s]         <= 8'h00;
        o_irq_acked_q[s] <= 1'b0;
      end
      else
      begin
        own_q[s]         <= own_d;
        irq_q[s]         <= irq_d;
        resp_q[s]        <= resp_d;
        o_irq_acked_q[s] <= hit;
        if (i_vec_we[s])
        begin
          vec_q[s] <= i_vec_wdata[s];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      as_prev_q        <= 1'b1;
      bus.br_oe_n      <= '1;
      bus.bbsy_bd_oe_n <= 1'b1;
      bus.irq_oe_n     <= '1;
      bus.data_drv     <= 8'h00;
      bus.data_oe_n    <= 1'b1;
      bus.dtack_oe_n   <= 1'b1;
      o_bus_own_q      <= '0;
    end
    else
    begin
      as_prev_q        <= bus.as_n;
      bus.br_oe_n      <= ~br_acc[NUM_SLOTS];
      bus.bbsy_bd_oe_n <= ~own_acc[NUM_SLOTS];
      bus.irq_oe_n     <= ~irq_acc[NUM_SLOTS];
      bus.data_drv     <= data_acc[NUM_SLOTS];
      bus.data_oe_n    <= ~resp_acc[NUM_SLOTS];
      bus.dtack_oe_n   <= ~resp_acc[NUM_SLOTS];
      o_bus_own_q      <= own_q;
    end
  end
endmodule : vmearb_boards
`default_nettype wire

// [hw/vmearb_sysctl.sv]
// System controller: bus arbiter on four request levels and interrupt acknowledge handler.
// Assumes boards resolve slot order on their grant and acknowledge daisy chains.
//
// Contract
// - Boards request, then wait for grant.
// - Master holds bus busy while owning.
// - Only the busy holder drives addresses.
// - Arbiter takes four request levels plus busy.
// - Bus clear is never driven.
// - Priority, round robin, release-on-request, combinable.
// - Reset selects straight priority.
// - Policy held in readable writable register.
// - Seven interrupt request levels watched.
// - Requester holds its line until acknowledged.
// - Level seven served first, one last.
// - Lowest slot wins within a level.
// - Detected request goes to processor to acknowledge.
// - Handler wins bus before acknowledge cycle.
// - Acknowledge drives IACK and level code.
// - Acknowledge passes slot by slot down chain.
// - Level sampled at address strobe falling edge.
// - Matching requester returns an 8-bit status byte.
// - Vector passed on with all eight bits.
// - Board keeps vector in register or preset.
`timescale 1ns/1ps
`default_nettype none
module vmearb_sysctl
  import vmearb_pkg::*;
(
  input  wire logic                  i_core_clk,    // Core clock.
  input  wire logic                  i_sys_rst,     // Synchronous reset, high.
  vmearb_if.sysctl                   bus,           // Backplane.
  input  wire logic                  i_cfg_we,      // Write the policy register.
  input  wire logic [CFG_W-1:0]      i_cfg_wdata,   // Policy bits to write.
  output logic      [CFG_W-1:0]      o_cfg_q,       // Policy register readback.
  input  wire logic                  i_ack_start,   // Pulse: processor starts acknowledge.
  output logic      [IRQ_LEVELS:1]   o_irq_pend_q,  // Pending interrupt levels.
  output logic      [LVL_W-1:0]      o_irq_top_q,   // Highest pending level, 0 none.
  output logic                       o_ack_busy_q,  // Acknowledge in progress.
  output logic                       o_vec_valid_q, // Pulse: vector captured.
  output logic      [VEC_W-1:0]      o_vector_q,    // Captured status/ID byte.
  output logic      [LVL_W-1:0]      o_vec_level_q, // Level that was acknowledged.
  output logic                       o_ack_err_q    // Pulse: no answer in time.
);
  vmearb_arb_type       arb_q;
  vmearb_arb_type       arb_d;
  vmearb_hnd_type       hnd_q;
  vmearb_hnd_type       hnd_d;
  logic [1:0]           last_q;
  logic [1:0]           last_d;
  logic [BR_LEVELS-1:0] bg_n_d;
  logic [BR_LEVELS-1:0] bg_n_q;
  logic [LVL_W-1:0]     lvl_q;
  logic [LVL_W-1:0]     lvl_d;
  logic [7:0]           cnt_q;
  logic [7:0]           cnt_d;
  logic [LVL_W-1:0]     top_lvl;
  logic                 vec_take;
  logic                 ack_err;

  wire                 use_rr   = o_cfg_q[CFG_RR_BIT];
  wire                 use_pri  = o_cfg_q[CFG_PRI_BIT] | ~use_rr;
  wire                 use_ror  = o_cfg_q[CFG_ROR_BIT];
  wire                 bus_free = bus.bbsy_n;
  wire [BR_LEVELS-1:0] br_req   = ~bus.br_n;
  wire [IRQ_LEVELS:1]  irq_pend = ~bus.irq_n;
  wire                 irq_any  = |irq_pend;

  // Returns {found, level}; the start level ranks first, then downward cyclically.
  function automatic logic [2:0] vmearb_pick(input logic [3:0] req, input logic [1:0] start);
    logic [1:0] idx;
    logic [2:0] res;
    res = 3'h0;
    for (int k = 3; k >= 0; k--)
    begin
      idx = start - 2'(k);
      if (req[idx])
      begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : vmearb_pick

  wire [2:0] pick_pri = vmearb_pick(br_req, 2'h3);
  wire [2:0] pick_rr  = vmearb_pick({br_req[3] & ~use_pri, br_req[2:0]}, last_q - 2'h1);
  wire       pri_top  = use_pri & br_req[3];
  wire [2:0] pick_sel = (use_rr & ~pri_top) ? pick_rr : pick_pri;

  always_comb
  begin
    top_lvl = 3'h0;
    for (int v = 1; v <= IRQ_LEVELS; v++)
    begin
      if (irq_pend[v])
      begin
        top_lvl = 3'(v);
      end
    end
  end

  always_comb
  begin
    arb_d  = arb_q;
    last_d = last_q;
    bg_n_d = bg_n_q;
    case (arb_q)
      ARB_IDLE:
      begin
        if (bus_free && hnd_q == HND_REQ)
        begin
          arb_d = ARB_OWN;
        end
        else if (bus_free && pick_sel[2])
        begin
          arb_d  = ARB_GRANT;
          last_d = pick_sel[1:0];
          bg_n_d = ~(4'h1 << pick_sel[1:0]);
        end
      end
      ARB_GRANT:
      begin
        if (!bus_free)
        begin
          arb_d  = ARB_BUSY;
          bg_n_d = '1;
        end
        else if (!br_req[last_q])
        begin
          arb_d  = ARB_IDLE;
          bg_n_d = '1;
        end
      end
      ARB_BUSY:
      begin
        if (bus_free)
        begin
          arb_d = ARB_IDLE;
        end
      end
      ARB_OWN:
      begin
        if (hnd_q == HND_IDLE && (!use_ror || |br_req))
        begin
          arb_d = ARB_IDLE;
        end
      end
      default:
      begin
        arb_d  = ARB_IDLE;
        bg_n_d = '1;
      end
    endcase
  end

  always_comb
  begin
    hnd_d    = hnd_q;
    lvl_d    = lvl_q;
    cnt_d    = cnt_q;
    vec_take = 1'b0;
    ack_err  = 1'b0;
    case (hnd_q)
      HND_IDLE:
      begin
        if (i_ack_start && irq_any)
        begin
          hnd_d = HND_REQ;
          lvl_d = top_lvl;
        end
      end
      HND_REQ:
      begin
        if (arb_q == ARB_OWN)
        begin
          hnd_d = HND_ADDR;
        end
      end
      HND_ADDR:
      begin
        hnd_d = HND_STROBE;
        cnt_d = 8'h00;
      end
      HND_STROBE:
      begin
        cnt_d = cnt_q + 8'h01;
        if (!bus.dtack_n)
        begin
          hnd_d    = HND_DONE;
          vec_take = 1'b1;
        end
        else if (cnt_q == ACK_TIMEOUT_CYC)
        begin
          hnd_d   = HND_DONE;
          ack_err = 1'b1;
        end
      end
      HND_DONE:
      begin
        hnd_d = HND_IDLE;
      end
      default:
      begin
        hnd_d = HND_IDLE;
      end
    endcase
  end

  wire drive_iack = (hnd_d == HND_ADDR) || (hnd_d == HND_STROBE);
  wire drive_as   = (hnd_d == HND_STROBE);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      arb_q <= ARB_IDLE;
      hnd_q <= HND_IDLE;
      last_q <= 2'h0;
      bg_n_q <= '1;
      lvl_q <= 3'h0;
      cnt_q <= 8'h00;
      o_cfg_q <= CFG_RESET;
    end
    else
    begin
      arb_q <= arb_d;
      hnd_q <= hnd_d;
      last_q <= last_d;
      bg_n_q <= bg_n_d;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      if (i_cfg_we)
      begin
        o_cfg_q <= i_cfg_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      bus.bg_n         <= '1;
      bus.bbsy_sc_oe_n <= 1'b1;
      bus.bclr_oe_n    <= 1'b1;
      bus.iack_n       <= 1'b1;
      bus.as_n         <= 1'b1;
      bus.ds_n         <= 1'b1;
      bus.addr_drv     <= 3'h0;
      bus.addr_oe_n    <= 1'b1;
      o_irq_pend_q     <= '0;
      o_irq_top_q      <= 3'h0;
      o_ack_busy_q     <= 1'b0;
      o_vec_valid_q    <= 1'b0;
      o_vector_q       <= 8'h00;
      o_vec_level_q    <= 3'h0;
      o_ack_err_q      <= 1'b0;
    end
    else
    begin
      bus.bg_n         <= bg_n_d;
      bus.bbsy_sc_oe_n <= ~(arb_d == ARB_OWN);
      bus.bclr_oe_n    <= 1'b1;
      bus.iack_n       <= ~drive_iack;
      bus.as_n         <= ~drive_as;
      bus.ds_n         <= ~drive_as;
      bus.addr_drv     <= lvl_d;
      bus.addr_oe_n    <= ~(drive_iack && arb_d == ARB_OWN);
      o_irq_pend_q     <= irq_pend;
      o_irq_top_q      <= top_lvl;
      o_ack_busy_q     <= (hnd_d != HND_IDLE);
      o_vec_valid_q    <= vec_take;
      o_ack_err_q      <= ack_err;
      if (vec_take)
      begin
        o_vector_q    <= bus.data;
        o_vec_level_q <= lvl_q;
      end
    end
  end
endmodule : vmearb_sysctl
`default_nettype wire

// [tb/vmearb_chk.sv]
// Checker on the backplane lines that join the controller and the boards.
// Assumes plain copies of the interface signals, all in one clock domain.
`timescale 1ns/1ps
`default_nettype none
module vmearb_chk
  import vmearb_pkg::*;
(
  input  wire logic                 i_core_clk,   // Core clock.
  input  wire logic                 i_sys_rst,    // Synchronous reset, high.
  input  wire logic [BR_LEVELS-1:0] br_n,         // Bus requests.
  input  wire logic [BR_LEVELS-1:0] bg_n,         // Bus grants.
  input  wire logic                 bbsy_n,       // Resolved bus busy.
  input  wire logic                 bbsy_sc_oe_n, // Controller busy drive.
  input  wire logic                 bclr_n,       // Bus clear.
  input  wire logic [IRQ_LEVELS:1]  irq_n,        // Interrupt requests.
  input  wire logic                 iack_n,       // Acknowledge.
  input  wire logic                 as_n,         // Address strobe.
  input  wire logic [LVL_W:1]       addr,         // Level code lines.
  input  wire logic                 addr_oe_n,    // Address drive enable.
  input  wire logic                 data_oe_n,    // Data drive enable.
  input  wire logic                 dtack_n       // Board answer.
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  no_clear_a: assert property (bclr_n)
    else $error("bus clear driven");
  one_grant_a: assert property ($onehot0(~bg_n))
    else $error("more than one grant");
  grant_free_a: assert property (
    (&$past(bg_n)) && !(&bg_n) |-> $past(bbsy_n) && !(&$past(br_n)))
    else $error("grant without free bus and request");
  grant_drop_a: assert property (!(&bg_n) && !bbsy_n |=> &bg_n)
    else $error("grant kept after busy taken");
  addr_owner_a: assert property (!addr_oe_n |-> !bbsy_sc_oe_n)
    else $error("address driven without busy");
  bus_won_a: assert property ($fell(bbsy_sc_oe_n) |-> $past(bbsy_n))
    else $error("handler took a busy bus");
  level_code_a: assert property (
    !iack_n && !as_n |-> !addr_oe_n && addr != 3'h0 && $stable(addr))
    else $error("level code not held");
  strobe_valid_a: assert property (
    $fell(as_n) |-> !$past(iack_n) && !$past(addr_oe_n))
    else $error("strobe before level code");
  answer_iack_a: assert property (
    $fell(dtack_n) |-> !iack_n && !as_n && !data_oe_n)
    else $error("answer outside acknowledge");
  irq_held_a: assert property (((irq_n & ~$past(irq_n)) != 7'h0) |-> !$past(iack_n))
    else $error("request dropped unacknowledged");

  cover property ($fell(bg_n[3]));
  cover property ($fell(dtack_n));
  cover property ($rose(bbsy_sc_oe_n) && !(&br_n));
endmodule : vmearb_chk
`default_nettype wire

// [tb/tb_top.sv]
// Testbench joining the system controller and the board end on one backplane.
// Assumes both ends share clock and reset; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vmearb_pkg::*;
  logic                            i_core_clk  = 1'h0;
  logic                            i_sys_rst   = 1'h1;
  logic                            i_cfg_we    = 1'h0;
  logic [CFG_W-1:0]                i_cfg_wdata = 3'h0;
  logic                            i_ack_start = 1'h0;
  logic [NUM_SLOTS-1:0]            i_bus_req   = '0;
  logic [NUM_SLOTS-1:0][1:0]       i_br_level  = '0;
  logic [NUM_SLOTS-1:0]            i_irq_req   = '0;
  logic [NUM_SLOTS-1:0][LVL_W-1:0] i_irq_level = '0;
  logic [NUM_SLOTS-1:0]            i_vec_we    = '0;
  logic [NUM_SLOTS-1:0][VEC_W-1:0] i_vec_wdata = '0;
  logic [CFG_W-1:0]                o_cfg_q;
  logic [IRQ_LEVELS:1]             o_irq_pend_q;
  logic [LVL_W-1:0]                o_irq_top_q;
  logic                            o_ack_busy_q;
  logic                            o_vec_valid_q;
  logic [VEC_W-1:0]                o_vector_q;
  logic [LVL_W-1:0]                o_vec_level_q;
  logic                            o_ack_err_q;
  logic [NUM_SLOTS-1:0]            o_bus_own_q;
  logic [NUM_SLOTS-1:0]            o_irq_acked_q;
  int                              num_errors  = 0;
  int                              compares    = 0;
  int                              cycles      = 0;

  vmearb_if vmearb_if_i ();
  vmearb_sysctl vmearb_sysctl_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(vmearb_if_i.sysctl),
    .i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata), .o_cfg_q(o_cfg_q),
    .i_ack_start(i_ack_start), .o_irq_pend_q(o_irq_pend_q), .o_irq_top_q(o_irq_top_q),
    .o_ack_busy_q(o_ack_busy_q), .o_vec_valid_q(o_vec_valid_q), .o_vector_q(o_vector_q),
    .o_vec_level_q(o_vec_level_q), .o_ack_err_q(o_ack_err_q)
  );
  vmearb_boards vmearb_boards_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(vmearb_if_i.boards),
    .i_bus_req(i_bus_req), .i_br_level(i_br_level), .i_irq_req(i_irq_req),
    .i_irq_level(i_irq_level), .i_vec_we(i_vec_we), .i_vec_wdata(i_vec_wdata),
    .o_bus_own_q(o_bus_own_q), .o_irq_acked_q(o_irq_acked_q)
  );
  vmearb_chk vmearb_chk_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .br_n(vmearb_if_i.br_n),
    .bg_n(vmearb_if_i.bg_n), .bbsy_n(vmearb_if_i.bbsy_n), .bclr_n(vmearb_if_i.bclr_n),
    .bbsy_sc_oe_n(vmearb_if_i.bbsy_sc_oe_n), .irq_n(vmearb_if_i.irq_n),
    .iack_n(vmearb_if_i.iack_n), .as_n(vmearb_if_i.as_n), .addr(vmearb_if_i.addr),
    .addr_oe_n(vmearb_if_i.addr_oe_n), .data_oe_n(vmearb_if_i.data_oe_n),
    .dtack_n(vmearb_if_i.dtack_n)
  );

  always #5 i_core_clk = ~i_core_clk;

  task automatic summarize;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  task automatic set_cfg(input logic [2:0] v);
    i_cfg_we = 1'h1;
    i_cfg_wdata = v;
    @(negedge i_core_clk);
    i_cfg_we = 1'h0;
    @(negedge i_core_clk);
    cmp_byte("policy readback", 8'(v), 8'(o_cfg_q));
  endtask : set_cfg

  task automatic req(input int s, input logic [1:0] lvl);
    i_br_level[s] = lvl;
    i_bus_req[s] = 1'h1;
  endtask : req

  task automatic wait_own(input logic want);
    int n;
    n = 0;
    while ((o_bus_own_q !== 8'h00) !== want && n < 80)
    begin
      @(negedge i_core_clk);
      n++;
    end
  endtask : wait_own

  // Waits for any owner, checks that it is this slot alone, then lets it go.
  task automatic take(input int s);
    wait_own(1'h1);
    cmp_byte("bus owner", 8'h01 << s, o_bus_own_q);
    i_bus_req[s] = 1'h0;
    wait_own(1'h0);
  endtask : take

  task automatic raise(input int s, input logic [2:0] lvl, input logic [7:0] vec);
    i_vec_wdata[s] = vec;
    i_irq_level[s] = lvl;
    i_vec_we[s] = 1'h1;
    i_irq_req[s] = 1'h1;
    @(negedge i_core_clk);
    i_vec_we[s] = 1'h0;
    i_irq_req[s] = 1'h0;
  endtask : raise

  task automatic start_ack;
    int n;
    n = 0;
    while (o_ack_busy_q !== 1'h0 && n < 300)
    begin
      @(negedge i_core_clk);
      n++;
    end
    repeat (2) @(negedge i_core_clk);
    i_ack_start = 1'h1;
    @(negedge i_core_clk);
    i_ack_start = 1'h0;
  endtask : start_ack

  // Collects the answer pulses while waiting, so the slot that answered is known.
  task automatic wait_vec(input int slot, input logic [7:0] vec, input logic [2:0] lvl);
    int                   n;
    logic [NUM_SLOTS-1:0] seen;
    logic                 err;
    n = 0;
    seen = '0;
    err = 1'h0;
    while (o_vec_valid_q !== 1'h1 && n < 300)
    begin
      @(negedge i_core_clk);
      seen = seen | o_irq_acked_q;
      err = err | o_ack_err_q;
      n++;
    end
    cmp_byte("vector valid", 8'h01, 8'(o_vec_valid_q));
    cmp_byte("vector", vec, o_vector_q);
    cmp_byte("acked level", 8'(lvl), 8'(o_vec_level_q));
    cmp_byte("answering slot", 8'h01 << slot, seen);
    cmp_byte("ack timeout", 8'h00, 8'(err));
  endtask : wait_vec

  task automatic t_config;
    cmp_byte("policy reset", 8'h01, 8'(o_cfg_q));
    cmp_byte("bus clear", 8'h01, 8'(vmearb_if_i.bclr_n));
    for (int v = 0; v < 8; v++)
      set_cfg(3'(v));
    set_cfg(3'h1);
  endtask : t_config

  task automatic t_arbitrate;
    req(3, 2'h0);
    req(5, 2'h3);
    take(5);
    take(3);
    req(6, 2'h1);
    req(2, 2'h1);
    take(2);
    take(6);
    set_cfg(3'h2);
    req(0, 2'h3);
    take(0);
    req(1, 2'h3);
    req(4, 2'h2);
    take(4);
    take(1);
    set_cfg(3'h1);
  endtask : t_arbitrate

  task automatic t_interrupt;
    raise(4, 3'h2, 8'hA5);
    raise(6, 3'h5, 8'h5A);
    raise(1, 3'h5, 8'hC3);
    repeat (3) @(negedge i_core_clk);
    cmp_byte("pending", 8'h12, 8'(o_irq_pend_q));
    cmp_byte("top level", 8'h05, 8'(o_irq_top_q));
    req(7, 2'h0);
    wait_own(1'h1);
    start_ack();
    repeat (20) @(negedge i_core_clk);
    cmp_byte("busy while bus held", 8'h01, 8'(o_ack_busy_q));
    cmp_byte("no early vector", 8'h00, o_vector_q);
    i_bus_req[7] = 1'h0;
    wait_vec(1, 8'hC3, 3'h5);
    repeat (3) @(negedge i_core_clk);
    cmp_byte("pending after first", 8'h12, 8'(o_irq_pend_q));
    start_ack();
    wait_vec(6, 8'h5A, 3'h5);
    start_ack();
    wait_vec(4, 8'hA5, 3'h2);
    repeat (3) @(negedge i_core_clk);
    cmp_byte("pending cleared", 8'h00, 8'(o_irq_pend_q));
    start_ack();
    repeat (5) @(negedge i_core_clk);
    cmp_byte("idle with none pending", 8'h00, 8'(o_ack_busy_q));
  endtask : t_interrupt

  task automatic t_release;
    set_cfg(3'h5);
    raise(0, 3'h7, 8'h81);
    start_ack();
    wait_vec(0, 8'h81, 3'h7);
    repeat (10) @(negedge i_core_clk);
    cmp_byte("busy kept", 8'h00, 8'(vmearb_if_i.bbsy_sc_oe_n));
    req(2, 2'h1);
    take(2);
  endtask : t_release

  initial
  begin
    repeat (8) @(negedge i_core_clk);
    i_sys_rst = 1'h0;
    @(negedge i_core_clk);
    t_config();
    t_arbitrate();
    t_interrupt();
    t_release();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
